// file: rtl/hdr_pixel_fmt.sv
`timescale 1ns/1ps
`include "hdr_consts.svh"

module hdr_pixel_fmt
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Readout configuration, taken at frame start
  input wire logic [1:0] mode_in,
  input wire logic [1:0] bin_in,
  // Imager sample pairs
  input wire logic smp_valid_in,
  input wire logic [`HDR_SMP_MSB:0] smp_hi_in,
  input wire logic [`HDR_SMP_MSB:0] smp_lo_in,
  output logic smp_ready_out,
  // Pixel stream to the frame grabber
  output logic pix_valid_out,
  output logic [`HDR_WORD_MSB:0] pix_word_out,
  output logic pix_frame_start_out,
  output logic pix_line_end_out,
  output logic pix_low_line_out
);

  hdr_pkg::hdr_state_t state;
  hdr_pkg::hdr_mode_t cfg_mode;
  hdr_pkg::hdr_bin_t cfg_bin;
  logic [11:0] col;
  logic [10:0] line;
  logic [`HDR_BUF_AW-1:0] rd_col;
  logic first_hi;

  hdr_pkg::hdr_mode_t pin_mode;
  hdr_pkg::hdr_bin_t pin_bin;
  hdr_pkg::hdr_mode_t cur_mode;
  hdr_pkg::hdr_bin_t cur_bin;
  logic at_frame_start;
  logic is_dual;
  logic take;
  logic [11:0] line_cols;
  logic [10:0] frame_lines;
  logic last_col;
  logic last_line;
  logic line_first_hi;
  logic replay_last;
  logic buf_we;
  logic [`HDR_SMP_MSB:0] buf_rd;
  logic [10:0] next_line;

  hdr_smp_if smp ();

  // Unused pin codes fall back to plain readout and full resolution
  assign pin_mode = (mode_in == hdr_pkg::HDR_MODE_DUAL) ?
                    hdr_pkg::HDR_MODE_DUAL :
                    (mode_in == hdr_pkg::HDR_MODE_DGS) ?
                    hdr_pkg::HDR_MODE_DGS : hdr_pkg::HDR_MODE_STATIC;
  assign pin_bin = (bin_in == hdr_pkg::HDR_BIN_2X2) ?
                   hdr_pkg::HDR_BIN_2X2 :
                   (bin_in == hdr_pkg::HDR_BIN_4X4) ?
                   hdr_pkg::HDR_BIN_4X4 : hdr_pkg::HDR_BIN_1X1;

  // Configuration changes only between frames
  assign at_frame_start = (state == hdr_pkg::HDR_ST_LIVE) &&
                          (col == `HDR_COL_ZERO) &&
                          (line == `HDR_LINE_ZERO);
  assign cur_mode = at_frame_start ? pin_mode : cfg_mode;
  assign is_dual = (cur_mode == hdr_pkg::HDR_MODE_DUAL);
  assign cur_bin = is_dual ? hdr_pkg::HDR_BIN_2X2 :
                   at_frame_start ? pin_bin : cfg_bin;

  assign line_cols = (cur_bin == hdr_pkg::HDR_BIN_2X2) ? `HDR_COLS_2X2 :
                     (cur_bin == hdr_pkg::HDR_BIN_4X4) ? `HDR_COLS_4X4 :
                     `HDR_COLS_1X1;
  assign frame_lines = (cur_bin == hdr_pkg::HDR_BIN_2X2) ? `HDR_LINES_2X2 :
                       (cur_bin == hdr_pkg::HDR_BIN_4X4) ? `HDR_LINES_4X4 :
                       `HDR_LINES_1X1;

  assign last_col = (col == (line_cols - `HDR_COL_ONE));
  assign last_line = (line == (frame_lines - `HDR_LINE_ONE));
  assign next_line = last_line ? `HDR_LINE_ZERO : (line + `HDR_LINE_ONE);
  assign take = smp_valid_in && smp_ready_out;

  assign line_first_hi = (line < `HDR_DUAL_HALF);
  assign replay_last = (rd_col == `HDR_BUF_LAST);

  assign smp.hi = smp_hi_in;
  assign smp.lo = smp_lo_in;
  assign smp.mode = cur_mode;
  assign smp.first_hi = line_first_hi;

  hdr_gain_sel u_gain_sel
  (
    .smp(smp.sel)
  );

  assign buf_we = take && is_dual;

  hdr_line_buf u_line_buf
  (
    .mclk_in(mclk_in),
    .wr_en_in(buf_we),
    .wr_addr_in(col[`HDR_BUF_AW-1:0]),
    .wr_data_in(smp.spare),
    .rd_addr_in(rd_col),
    .rd_data_out(buf_rd)
  );

  // Frame configuration latch
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cfg_mode <= hdr_pkg::HDR_MODE_STATIC;
      cfg_bin <= hdr_pkg::HDR_BIN_1X1;
    end
    else if (take && at_frame_start)
    begin
      cfg_mode <= cur_mode;
      cfg_bin <= cur_bin;
    end
  end

  // Sequencer: live line, then replay of the stored line in dual mode
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state <= hdr_pkg::HDR_ST_LIVE;
      col <= `HDR_COL_ZERO;
      line <= `HDR_LINE_ZERO;
      rd_col <= `HDR_BUF_ZERO;
      first_hi <= 1'b1;
      smp_ready_out <= 1'b1;
    end
    else
    begin
      unique case (state)
        hdr_pkg::HDR_ST_LIVE:
        begin
          if (take && last_col)
          begin
            col <= `HDR_COL_ZERO;
            rd_col <= `HDR_BUF_ZERO;
            first_hi <= line_first_hi;
            if (is_dual)
            begin
              state <= hdr_pkg::HDR_ST_REPLAY;
              smp_ready_out <= 1'b0;
            end
            else
            begin
              line <= next_line;
            end
          end
          else if (take)
          begin
            col <= col + `HDR_COL_ONE;
          end
        end
        hdr_pkg::HDR_ST_REPLAY:
        begin
          rd_col <= rd_col + `HDR_BUF_ONE;
          if (replay_last)
          begin
            state <= hdr_pkg::HDR_ST_LIVE;
            smp_ready_out <= 1'b1;
            line <= next_line;
          end
        end
      endcase
    end
  end

  // Registered pixel outputs
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pix_valid_out <= 1'b0;
      pix_word_out <= {`HDR_WORD_W{1'b0}};
      pix_frame_start_out <= 1'b0;
      pix_line_end_out <= 1'b0;
      pix_low_line_out <= 1'b0;
    end
    else if (state == hdr_pkg::HDR_ST_REPLAY)
    begin
      pix_valid_out <= 1'b1;
      pix_word_out <= {`HDR_PAD2, buf_rd};
      pix_frame_start_out <= 1'b0;
      pix_line_end_out <= replay_last;
      pix_low_line_out <= first_hi;
    end
    else
    begin
      pix_valid_out <= take;
      pix_word_out <= take ? smp.word : pix_word_out;
      pix_frame_start_out <= take && at_frame_start;
      pix_line_end_out <= take && last_col;
      pix_low_line_out <= take && is_dual && !line_first_hi;
    end
  end

endmodule

// file: shared/hdr_consts.svh
`ifndef HDR_CONSTS_SVH
`define HDR_CONSTS_SVH

// Sample and pixel word layout
`define HDR_SMP_W 14
`define HDR_SMP_MSB 13
`define HDR_WORD_W 16
`define HDR_WORD_MSB 15
`define HDR_GAIN_BIT 14
`define HDR_PAD2 2'h0
`define HDR_PAD1 1'h0

// High-gain level at and above which a pixel is taken at low gain
`define HDR_SAT_LEVEL 14'h3f00

// Frame geometry per binning
`define HDR_COLS_1X1 12'h800
`define HDR_COLS_2X2 12'h400
`define HDR_COLS_4X4 12'h200
`define HDR_LINES_1X1 11'h600
`define HDR_LINES_2X2 11'h300
`define HDR_LINES_4X4 11'h180
`define HDR_DUAL_HALF 11'h180

// Counter steps and reset values
`define HDR_COL_ONE 12'h001
`define HDR_COL_ZERO 12'h000
`define HDR_LINE_ONE 11'h001
`define HDR_LINE_ZERO 11'h000

// Line store
`define HDR_BUF_DEPTH 1024
`define HDR_BUF_AW 10
`define HDR_BUF_ZERO 10'h000
`define HDR_BUF_ONE 10'h001
`define HDR_BUF_LAST 10'h3ff

`endif

// file: shared/hdr_pkg.sv
package hdr_pkg;

  typedef enum logic [1:0]
  {
    HDR_MODE_STATIC,
    HDR_MODE_DUAL,
    HDR_MODE_DGS
  } hdr_mode_t;

  typedef enum logic [1:0]
  {
    HDR_BIN_1X1,
    HDR_BIN_2X2,
    HDR_BIN_4X4
  } hdr_bin_t;

  typedef enum logic
  {
    HDR_ST_LIVE,
    HDR_ST_REPLAY
  } hdr_state_t;

endpackage

// file: shared/hdr_smp_if.sv
`timescale 1ns/1ps
`include "hdr_consts.svh"

interface hdr_smp_if;
  logic [`HDR_SMP_MSB:0] hi;
  logic [`HDR_SMP_MSB:0] lo;
  hdr_pkg::hdr_mode_t mode;
  logic first_hi;
  logic [`HDR_WORD_MSB:0] word;
  logic [`HDR_SMP_MSB:0] spare;

  modport sel
  (
    input hi,
    input lo,
    input mode,
    input first_hi,
    output word,
    output spare
  );

  modport top
  (
    output hi,
    output lo,
    output mode,
    output first_hi,
    input word,
    input spare
  );
endinterface

// file: rtl/hdr_gain_sel.sv
`timescale 1ns/1ps
`include "hdr_consts.svh"

module hdr_gain_sel
(
  // Sample pair in, pixel word out
  hdr_smp_if.sel smp
);

  logic is_low;
  logic [`HDR_SMP_MSB:0] dgs_smp;
  logic [`HDR_WORD_MSB:0] dgs_word;
  logic [`HDR_SMP_MSB:0] dual_first;

  assign is_low = (smp.hi >= `HDR_SAT_LEVEL);
  assign dgs_smp = is_low ? smp.lo : smp.hi;
  assign dgs_word = {`HDR_PAD1, is_low, dgs_smp};

  assign dual_first = smp.first_hi ? smp.hi : smp.lo;
  assign smp.spare = smp.first_hi ? smp.lo : smp.hi;

  assign smp.word = (smp.mode == hdr_pkg::HDR_MODE_DGS) ? dgs_word :
                    (smp.mode == hdr_pkg::HDR_MODE_DUAL) ?
                    {`HDR_PAD2, dual_first} : {`HDR_PAD2, smp.hi};

endmodule

// file: rtl/hdr_line_buf.sv
`timescale 1ns/1ps
`include "hdr_consts.svh"

module hdr_line_buf
(
  // Clock
  input wire logic mclk_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [`HDR_BUF_AW-1:0] wr_addr_in,
  input wire logic [`HDR_SMP_MSB:0] wr_data_in,
  // Read side
  input wire logic [`HDR_BUF_AW-1:0] rd_addr_in,
  output logic [`HDR_SMP_MSB:0] rd_data_out
);

  logic [`HDR_SMP_MSB:0] mem [`HDR_BUF_DEPTH];

  // Holds the second-gain samples of one binned line
  always_ff @(posedge mclk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem[rd_addr_in];

endmodule

// file: tb/hdr_pixel_fmt_properties.sv
`timescale 1ns/1ps
`include "hdr_consts.svh"

module hdr_pixel_fmt_props
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Watched inputs
  input wire logic [1:0] mode_in,
  input wire logic smp_valid_in,
  input wire logic [13:0] smp_hi_in,
  input wire logic [13:0] smp_lo_in,
  // Watched outputs
  input wire logic smp_ready_out,
  input wire logic pix_valid_out,
  input wire logic [15:0] pix_word_out,
  input wire logic pix_frame_start_out,
  input wire logic pix_low_line_out
);
  logic [10:0] low_cnt;
  wire take = smp_valid_in && smp_ready_out;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Length of each refused stretch
  always_ff @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in)
      low_cnt <= 11'h000;
    else if (smp_ready_out)
      low_cnt <= 11'h000;
    else
      low_cnt <= low_cnt + 11'h001;
  a_answer_next:
    assert property (take |=> pix_valid_out) else $error("No word");
  a_top_bit_zero:
    assert property (pix_valid_out |-> !pix_word_out[15])
    else $error("Top bit set");
  a_dgs_word:
    assert property (take && mode_in == 2'h2 |=> pix_word_out ==
      ($past(smp_hi_in) >= `HDR_SAT_LEVEL ? {2'h1, $past(smp_lo_in)}
      : {2'h0, $past(smp_hi_in)})) else $error("Bad switched word");
  a_dual_word:
    assert property (take && mode_in == 2'h1 |=> pix_word_out == {2'h0,
      pix_low_line_out ? $past(smp_lo_in) : $past(smp_hi_in)})
    else $error("Bad dual word");
  a_replay_len:
    assert property ($rose(smp_ready_out) |-> low_cnt == 11'h400)
    else $error("Replay length");
  a_replay_words:
    assert property (!smp_ready_out && $past(smp_ready_out) == 1'b0
      |-> pix_valid_out) else $error("Replay gap");
  a_no_spurious:
    assert property (pix_valid_out && smp_ready_out && $past(smp_ready_out)
      |-> $past(take)) else $error("Word without take");
  a_first_high:
    assert property (pix_frame_start_out |-> pix_valid_out
      && !pix_low_line_out) else $error("Frame start");
  a_flag_dual:
    assert property (pix_valid_out && pix_low_line_out
      |-> !pix_word_out[14]) else $error("Flag in dual");
endmodule

bind hdr_pixel_fmt hdr_pixel_fmt_props i_props
(
  .mclk_in, .reset_n_in, .mode_in, .smp_valid_in, .smp_hi_in, .smp_lo_in,
  .smp_ready_out, .pix_valid_out, .pix_word_out, .pix_frame_start_out,
  .pix_low_line_out
);

// file: tb/hdr_grabber_model.sv
`timescale 1ns/1ps

module hdr_grabber_model
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Pixel stream
  input wire logic pix_valid_in,
  input wire logic pix_frame_start_in,
  input wire logic pix_line_end_in,
  // Geometry seen
  output logic [11:0] line_len_out,
  output logic [11:0] lines_out
);
  logic [11:0] run;
  wire [11:0] next_run = pix_frame_start_in ? 12'h001 : run + 12'h001;
  always_ff @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      run <= 12'h000;
      line_len_out <= 12'h000;
      lines_out <= 12'h000;
    end
    else if (pix_valid_in)
    begin
      run <= pix_line_end_in ? 12'h000 : next_run;
      if (pix_line_end_in)
      begin
        line_len_out <= next_run;
        lines_out <= lines_out + 12'h001;
      end
    end
endmodule

// file: tb/hdr_pixel_fmt_tb_top.sv
`timescale 1ns/1ps

module hdr_pixel_fmt_tb_top;
  logic mclk_in, reset_n_in, smp_valid_in, smp_ready_out, pix_valid_out;
  logic pix_frame_start_out, pix_line_end_out, pix_low_line_out;
  logic [1:0] mode_in, bin_in;
  logic [13:0] smp_hi_in, smp_lo_in;
  logic [15:0] pix_word_out;
  logic [11:0] line_len, lines;
  logic [31:0] seed = 32'h0000b1d8;
  logic [18:0] expq[$];
  logic [13:0] lows[$];
  int n_fail = 0, samples_checked = 0, md, wid, col, ln, b;

  hdr_pixel_fmt i_dut (.mclk_in, .reset_n_in, .mode_in, .bin_in,
    .smp_valid_in, .smp_hi_in, .smp_lo_in, .smp_ready_out, .pix_valid_out,
    .pix_word_out, .pix_frame_start_out, .pix_line_end_out,
    .pix_low_line_out);
  hdr_grabber_model i_host (.mclk_in, .reset_n_in,
    .pix_valid_in(pix_valid_out), .pix_frame_start_in(pix_frame_start_out),
    .pix_line_end_in(pix_line_end_out), .line_len_out(line_len),
    .lines_out(lines));

  initial
  begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [15:0] expw(input int m, input logic [13:0] h, l);
    if (m == 2 && h >= 14'h3f00)
      return {2'h1, l};
    return {2'h0, h};
  endfunction

  task automatic check(input string nm, input logic [18:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge mclk_in)
    if (pix_valid_out === 1'b1)
      check("pixel", {pix_frame_start_out, pix_line_end_out, pix_low_line_out,
        pix_word_out}, expq.pop_front());

  task automatic rst(input logic [1:0] m, bb, input int w);
    smp_valid_in <= 1'b0;
    mode_in <= m;
    bin_in <= bb;
    reset_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    md = (m == 2'h3) ? 0 : m;
    wid = w;
    col = 0;
    ln = 0;
  endtask

  // Offer one pair and hold it until taken
  task automatic px(input logic [13:0] h, l);
    int n;
    logic lf;
    smp_valid_in <= 1'b1;
    smp_hi_in <= h;
    smp_lo_in <= l;
    for (n = 0; n < 2000; n++)
    begin
      @(negedge mclk_in);
      if (smp_ready_out === 1'b1)
        break;
    end
    if (n == 2000)
    begin
      n_fail++;
      results();
    end
    @(posedge mclk_in);
    // Past the midpoint the live line is the low-gain one
    lf = (md == 1) && (ln >= 384);
    expq.push_back({col == 0 && ln == 0, col == wid - 1, lf,
      (md == 1) ? {2'h0, lf ? l : h} : expw(md, h, l)});
    if (md == 1)
      lows.push_back(lf ? h : l);
    if (md == 1 && col == wid - 1)
      for (n = 0; n < wid; n++)
        expq.push_back({1'b0, n == wid - 1, !lf, 2'h0, lows.pop_front()});
    col = (col == wid - 1) ? 0 : col + 1;
    if (col == 0)
      ln++;
  endtask

  task automatic nxt();
    seed = xorshift(seed);
    px(seed[30] ? {6'h3f, seed[7:0]} : seed[13:0], seed[27:14]);
  endtask

  task automatic drain(input int nl);
    smp_valid_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check("line", {7'h00, line_len}, 19'(wid));
    check("lines", {7'h00, lines}, 19'(nl));
    check("left", 19'(expq.size()), 19'h00000);
  endtask

  initial
  begin
    smp_hi_in <= 14'h0000;
    smp_lo_in <= 14'h0000;
    rst(2'h3, 2'h3, 2048);
    repeat (2052) nxt();
    drain(1);
    // Plain readout code with two-by-two binning
    rst(2'h0, 2'h1, 1024);
    repeat (1028) nxt();
    drain(1);
    for (b = 0; b < 3; b++)
    begin
      rst(2'h2, 2'(b), 2048 >> b);
      px(14'h3eff, 14'h0001);
      px(14'h3f00, 14'h2aaa);
      px(14'h3fff, 14'h3fff);
      px(14'h0000, 14'h0000);
      repeat ((2048 >> b) + 4) nxt();
      drain(1);
    end
    // Dual gain with the binning code ignored
    rst(2'h1, 2'h0, 1024);
    repeat (1028) nxt();
    drain(2);
    results();
  end
endmodule
